// File: hdl/ref_nvm_pkg.sv
// Register map, field positions and encodings for the reference status and NVM control bank
// Overview of operation
// - A reference's valid flag (bit 7 second, bit 3 first) is set only while it is unfaulted and its validation timer has expired.
// - A reference's fault flag (bit 6 second, bit 2 first) is set whenever that reference's monitor reports a fault.
// - A reference's fast flag (bit 5 second, bit 1 first) is set when its frequency is above its profile's upper limit.
// - A reference's slow flag (bit 4 second, bit 0 first) is set when its frequency is below its profile's lower limit.
// - A missing clock on a reference shows as its fast and slow flags both set.
// - Reference status refreshes only when 0x01 is written to index 0x0005, which the host must do before reading.
// - The current 30-bit oscillator tuning word reads back over four bytes, least significant at index 0x0D0D.
// - The 12-bit phase lock level reads as bits 7:0 at 0x0D11 and bits 11:8 in the low nibble of 0x0D12.
// - The 12-bit frequency lock level reads as bits 7:0 at 0x0D13 and bits 11:8 in the low nibble of 0x0D14.
// - Bit 0 of 0x0E00 acts at once on write; 0 after reset protects the NVM and 1 permits writes.
// - The 4-bit load condition in bits 3:0 of 0x0E01 resets to 0, acts at once and governs loads when nonzero.
// - Writing 1 to bit 0 of 0x0E02 starts a save at once and the bit clears itself.
// - Writing 1 to bit 1 of 0x0E03 starts a load at once and the bit clears itself.
// - Index 0x0D03 raises bit 0 when a save or load completes and bit 1 when one faults.
package ref_nvm_pkg;

  localparam int IDX_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_XFER      = 12'h005;
  localparam logic [IDX_W-1:0] IDX_NVM_BUSY  = 12'hD00;
  localparam logic [IDX_W-1:0] IDX_EVT_STAT  = 12'hD03;
  localparam logic [IDX_W-1:0] IDX_REF_STAT  = 12'hD0B;
  localparam logic [IDX_W-1:0] IDX_RSVD_D0C  = 12'hD0C;
  localparam logic [IDX_W-1:0] IDX_TW0       = 12'hD0D;
  localparam logic [IDX_W-1:0] IDX_TW1       = 12'hD0E;
  localparam logic [IDX_W-1:0] IDX_TW2       = 12'hD0F;
  localparam logic [IDX_W-1:0] IDX_TW3       = 12'hD10;
  localparam logic [IDX_W-1:0] IDX_PH_LO     = 12'hD11;
  localparam logic [IDX_W-1:0] IDX_PH_HI     = 12'hD12;
  localparam logic [IDX_W-1:0] IDX_FR_LO     = 12'hD13;
  localparam logic [IDX_W-1:0] IDX_FR_HI     = 12'hD14;
  localparam logic [IDX_W-1:0] IDX_EVT_EN    = 12'hD20;
  localparam logic [IDX_W-1:0] IDX_EVT_CLR   = 12'hD21;
  localparam logic [IDX_W-1:0] IDX_WPROT     = 12'hE00;
  localparam logic [IDX_W-1:0] IDX_LOAD_COND = 12'hE01;
  localparam logic [IDX_W-1:0] IDX_SAVE_TRIG = 12'hE02;
  localparam logic [IDX_W-1:0] IDX_LOAD_TRIG = 12'hE03;

  // Field positions
  localparam int BIT_BUSY      = 1;
  localparam int BIT_EVT_DONE  = 0;
  localparam int BIT_EVT_FAULT = 1;
  localparam int BIT_WEN       = 0;
  localparam int BIT_SAVE      = 0;
  localparam int BIT_LOAD      = 1;
  localparam int EVT_W         = 2;
  localparam int COND_W        = 4;

  localparam logic [7:0]        XFER_CMD   = 8'h01;
  localparam logic [COND_W-1:0] COND_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // NVM sequencer states, Gray along idle -> save/load
  typedef enum logic [1:0] {
    NVM_IDLE = 2'b00,
    NVM_SAVE = 2'b01,
    NVM_LOAD = 2'b10
  } nvm_state_t;

endpackage

// File: hdl/ref_status_nvm_ctrl.sv
// AXI4-Lite register bank: reference status, tuning and lock readback, NVM control
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ref_status_nvm_ctrl #(
  parameter int ADDR_W = 16,
  parameter int TW_W   = 30,
  parameter int TUB_W  = 12
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [ADDR_W-1:0]               s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // Reference monitors, index 0 first reference, index 1 second
  input  wire logic [1:0]                      ref_fault,
  input  wire logic [1:0]                      ref_timer_done,
  input  wire logic [1:0]                      ref_fast,
  input  wire logic [1:0]                      ref_slow,
  input  wire logic [1:0]                      ref_missing,
  // History and lock detect readback
  input  wire logic [TW_W-1:0]                 tuning_word,
  input  wire logic [TUB_W-1:0]                phase_lock_level,
  input  wire logic [TUB_W-1:0]                freq_lock_level,
  // NVM sequencer
  output logic                                 nvm_save_start,
  output logic                                 nvm_load_start,
  output logic                                 nvm_write_enable,
  output logic [ref_nvm_pkg::COND_W-1:0]       nvm_load_condition,
  input  wire logic                            nvm_done,
  input  wire logic                            nvm_error,
  output logic                                 irq
);
  import ref_nvm_pkg::*;

  // Flags of one reference, {valid, fault, fast, slow}
  function automatic logic [3:0] ref_flags(input logic fault, input logic timer_done,
                                           input logic fast, input logic slow,
                                           input logic missing);
    ref_flags = {~fault & timer_done,
                 fault,
                 fast | missing,
                 slow | missing};
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_XFER,
      IDX_NVM_BUSY,
      IDX_EVT_STAT,
      IDX_REF_STAT,
      IDX_RSVD_D0C,
      IDX_TW0,
      IDX_TW1,
      IDX_TW2,
      IDX_TW3,
      IDX_PH_LO,
      IDX_PH_HI,
      IDX_FR_LO,
      IDX_FR_HI,
      IDX_EVT_EN,
      IDX_EVT_CLR,
      IDX_WPROT,
      IDX_LOAD_COND,
      IDX_SAVE_TRIG,
      IDX_LOAD_TRIG: is_mapped = 1'b1;
      default:                      is_mapped = 1'b0;
    endcase
  endfunction

  logic [IDX_W-1:0]  aw_idx_q;
  logic              aw_full_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              w_full_q;
  logic              wr_fire;
  logic              wr_byte;
  logic [7:0]        ref_stat_q;
  logic [TW_W-1:0]   tw_q;
  logic [TUB_W-1:0]  ph_q;
  logic [TUB_W-1:0]  fr_q;
  logic [EVT_W-1:0]  evt_stat_q;
  logic [EVT_W-1:0]  evt_en_q;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  nvm_state_t        nvm_q;
  logic              save_req;
  logic              load_req;
  logic [31:0]       tw_ext;
  logic [7:0]        rd_byte;
  logic [IDX_W-1:0]  ar_idx;
  logic              hit_xfer;
  logic              hit_evt_en;
  logic              hit_evt_clr;
  logic              hit_wprot;
  logic              hit_cond;
  logic              hit_save;
  logic              hit_load;
  logic [7:0]        ref_now;
  logic [1:0]        wr_resp;
  logic [1:0]        rd_resp;

  // Only byte lane 0 carries data; upper lanes are ignored
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_byte = wr_fire & wlane_q & is_mapped(aw_idx_q);

  // One strobe per writable register, high in the cycle the write commits
  assign hit_xfer    = wr_byte && aw_idx_q == IDX_XFER;
  assign hit_evt_en  = wr_byte && aw_idx_q == IDX_EVT_EN;
  assign hit_evt_clr = wr_byte && aw_idx_q == IDX_EVT_CLR;
  assign hit_wprot   = wr_byte && aw_idx_q == IDX_WPROT;
  assign hit_cond    = wr_byte && aw_idx_q == IDX_LOAD_COND;
  assign hit_save    = wr_byte && aw_idx_q == IDX_SAVE_TRIG;
  assign hit_load    = wr_byte && aw_idx_q == IDX_LOAD_TRIG;

  assign save_req = hit_save && wbyte_q[BIT_SAVE];
  assign load_req = hit_load && wbyte_q[BIT_LOAD];
  assign evt_clr  = hit_evt_clr ? wbyte_q[EVT_W-1:0] : '0;
  // Bits above the tuning word read as zero
  assign tw_ext   = {{(32-TW_W){1'b0}}, tw_q};
  assign ar_idx   = s_axi_araddr[IDX_W+1:2];
  assign wr_resp  = is_mapped(aw_idx_q) ? RESP_OKAY : RESP_DECERR;
  assign rd_resp  = is_mapped(ar_idx) ? RESP_OKAY : RESP_DECERR;

  // Both references decoded alike, second reference in the upper nibble
  assign ref_now = {ref_flags(ref_fault[1], ref_timer_done[1], ref_fast[1], ref_slow[1],
                              ref_missing[1]),
                    ref_flags(ref_fault[0], ref_timer_done[0], ref_fast[0], ref_slow[0],
                              ref_missing[0])};

  // Write address channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_full_q     <= 1'b0;
      aw_idx_q      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full_q     <= 1'b1;
      aw_idx_q      <= s_axi_awaddr[IDX_W+1:2];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_full_q     <= 1'b0;
    end else if (!aw_full_q) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address
  // Readies come back only with the response, so one write is in flight at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_full_q     <= 1'b0;
      wbyte_q      <= '0;
      wlane_q      <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full_q     <= 1'b1;
      wbyte_q      <= s_axi_wdata[7:0];
      wlane_q      <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_full_q     <= 1'b0;
    end else if (!w_full_q) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response once both halves are held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Status snapshot: held until the host issues the transfer strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_stat_q <= '0;
    end else if (hit_xfer && wbyte_q == XFER_CMD) begin
      ref_stat_q <= ref_now;
    end
  end

  // Readback values track their sources every cycle
  // Unlike reference status they are not held for the transfer strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tw_q <= '0;
      ph_q <= '0;
      fr_q <= '0;
    end else begin
      tw_q <= tuning_word;
      ph_q <= phase_lock_level;
      fr_q <= freq_lock_level;
    end
  end

  // Live NVM configuration, no transfer strobe needed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvm_write_enable   <= 1'b0;
      nvm_load_condition <= COND_RESET;
    end else if (hit_wprot) begin
      nvm_write_enable   <= wbyte_q[BIT_WEN];
    end else if (hit_cond) begin
      nvm_load_condition <= wbyte_q[COND_W-1:0];
    end
  end

  // NVM sequencer: a request while busy is ignored, the sequencer finishes first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvm_q          <= NVM_IDLE;
      nvm_save_start <= 1'b0;
      nvm_load_start <= 1'b0;
    end else begin
      nvm_save_start <= 1'b0;
      nvm_load_start <= 1'b0;
      case (nvm_q)
        NVM_IDLE: begin
          // A protected save stays idle, so no start pulse reaches the NVM
          if (save_req && nvm_write_enable) begin
            nvm_q          <= NVM_SAVE;
            nvm_save_start <= 1'b1;
          end else if (load_req) begin
            nvm_q          <= NVM_LOAD;
            nvm_load_start <= 1'b1;
          end
        end
        NVM_SAVE, NVM_LOAD: begin
          if (nvm_done || nvm_error) begin
            nvm_q <= NVM_IDLE;
          end
        end
        default: nvm_q <= NVM_IDLE;
      endcase
    end
  end

  // Completion and fault events; a protected save is refused and reported as a fault
  always_comb begin
    evt_set = '0;
    if (nvm_q != NVM_IDLE && nvm_done && !nvm_error) begin
      evt_set[BIT_EVT_DONE] = 1'b1;
    end
    if (nvm_q != NVM_IDLE && nvm_error) begin
      evt_set[BIT_EVT_FAULT] = 1'b1;
    end
    if (nvm_q == NVM_IDLE && save_req && !nvm_write_enable) begin
      evt_set[BIT_EVT_FAULT] = 1'b1;
    end
  end

  // Sticky flags: a set in the same cycle as its clear wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_stat_q <= '0;
    end else begin
      evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
    end
  end

  // The mask only gates the interrupt; status bits collect regardless
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_en_q <= '0;
    end else if (hit_evt_en) begin
      evt_en_q <= wbyte_q[EVT_W-1:0];
    end
  end

  // Registered so the pin cannot glitch while status and mask change together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat_q & evt_en_q);
    end
  end

  // Read byte mux; reserved and write-only fields read as zero
  always_comb begin
    rd_byte = '0;
    case (ar_idx)
      IDX_NVM_BUSY:  rd_byte[BIT_BUSY] = (nvm_q != NVM_IDLE);
      IDX_EVT_STAT:  rd_byte[EVT_W-1:0] = evt_stat_q;
      IDX_REF_STAT:  rd_byte = ref_stat_q;
      IDX_TW0:       rd_byte = tw_ext[7:0];
      IDX_TW1:       rd_byte = tw_ext[15:8];
      IDX_TW2:       rd_byte = tw_ext[23:16];
      IDX_TW3:       rd_byte = tw_ext[31:24];
      IDX_PH_LO:     rd_byte = ph_q[7:0];
      IDX_PH_HI:     rd_byte[TUB_W-9:0] = ph_q[TUB_W-1:8];
      IDX_FR_LO:     rd_byte = fr_q[7:0];
      IDX_FR_HI:     rd_byte[TUB_W-9:0] = fr_q[TUB_W-1:8];
      IDX_EVT_EN:    rd_byte[EVT_W-1:0] = evt_en_q;
      IDX_WPROT:     rd_byte[BIT_WEN] = nvm_write_enable;
      IDX_LOAD_COND: rd_byte[COND_W-1:0] = nvm_load_condition;
      IDX_SAVE_TRIG: rd_byte[BIT_SAVE] = (nvm_q == NVM_SAVE);
      IDX_LOAD_TRIG: rd_byte[BIT_LOAD] = (nvm_q == NVM_LOAD);
      default:       rd_byte = '0;
    endcase
  end

  // Read channel: one read at a time, answered the cycle after acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: dv/ref_nvm_ctrl_assertions.sv
// Concurrent checks on the bus handshakes and NVM control outputs of the register bank
`timescale 1ns/1ps
module ref_nvm_chk (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          nvm_save_start,
  input wire logic                          nvm_load_start,
  input wire logic                          nvm_write_enable,
  input wire logic [ref_nvm_pkg::COND_W-1:0] nvm_load_condition
);
  import ref_nvm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Every register is one byte wide, so the upper lanes must read back as zero
  sequence read_answered;
    s_axi_rvalid && (s_axi_rdata[31:8] == 24'h0);
  endsequence

  a_read_answer_byte: assert property (read_taken |=> read_answered)
    else $error("read answer missing or upper bytes not zero");
  a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed early");
  a_save_pulse_once: assert property (nvm_save_start |=> !nvm_save_start)
    else $error("save start longer than one cycle");
  a_load_pulse_once: assert property (nvm_load_start |=> !nvm_load_start)
    else $error("load start longer than one cycle");
  a_save_needs_enable: assert property (nvm_save_start |-> nvm_write_enable)
    else $error("save started while writes are protected");
  a_save_after_write: assert property (nvm_save_start |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("save started without a bus write");
  a_load_after_write: assert property (nvm_load_start |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("load started without a bus write");
  a_wen_live_write: assert property ($changed(nvm_write_enable) |-> s_axi_bvalid)
    else $error("write enable moved outside a write commit");
  a_cond_live_write: assert property ($changed(nvm_load_condition) |-> $rose(s_axi_bvalid))
    else $error("load condition moved outside a write commit");
endmodule

bind ref_status_nvm_ctrl ref_nvm_chk u_chk (
  .clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .nvm_save_start, .nvm_load_start,
  .nvm_write_enable, .nvm_load_condition
);

// File: dv/tb.sv
// Self-checking bench for the reference status and NVM control register bank
`timescale 1ns/1ps
module tb;
  import ref_nvm_pkg::*;
  logic        clk, rst;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, nvm_load_condition;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  ref_fault, ref_timer_done, ref_fast, ref_slow, ref_missing;
  logic [29:0] tuning_word;
  logic [11:0] phase_lock_level, freq_lock_level;
  logic        nvm_save_start, nvm_load_start, nvm_write_enable, nvm_done, nvm_error, irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n_save = 0;
  int          n_load = 0;

  ref_status_nvm_ctrl dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ref_fault, .ref_timer_done, .ref_fast, .ref_slow, .ref_missing, .tuning_word,
    .phase_lock_level, .freq_lock_level, .nvm_save_start, .nvm_load_start, .nvm_write_enable,
    .nvm_load_condition, .nvm_done, .nvm_error, .irq
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counted on the falling edge so the one-cycle pulses are never raced
  always @(negedge clk) begin
    if (nvm_save_start === 1'b1) n_save++;
    if (nvm_load_start === 1'b1) n_load++;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx);
    @(posedge clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(what, rdat, {24'h0, exp});
  endtask

  // Input pattern is {fault, timer_done, fast, slow, missing}, two bits each
  function automatic logic [7:0] ref_exp(input logic [9:0] c);
    logic [7:0] e;
    for (int i = 0; i < 2; i++) begin
      e[4*i+3] = ~c[8+i] & c[6+i];
      e[4*i+2] = c[8+i];
      e[4*i+1] = c[4+i] | c[i];
      e[4*i]   = c[2+i] | c[i];
    end
    return e;
  endfunction

  task automatic t_reset_and_map;
    chk("wen_pin", nvm_write_enable, 1'b0);
    chk("cond_pin", nvm_load_condition, 4'h0);
    rchk("wprot", IDX_WPROT, 8'h00);
    chk("mapped_rresp", rsp, RESP_OKAY);
    rchk("cond", IDX_LOAD_COND, 8'h00);
    rchk("rsvd", IDX_RSVD_D0C, 8'h00);
    rd(12'h7FF);
    chk("unmapped_rresp", rsp, RESP_DECERR);
    wr(12'h7FF, 8'hFF);
    chk("unmapped_bresp", rsp, RESP_DECERR);
  endtask

  task automatic t_ref_status;
    logic [9:0] cs [4] = '{10'h0C0, 10'h190, 10'h248, 10'h303};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {ref_fault, ref_timer_done, ref_fast, ref_slow, ref_missing} <= cs[k];
      if (k > 0) begin
        wr(IDX_XFER, 8'h02);
        rchk("ref_stale", IDX_REF_STAT, ref_exp(cs[k-1]));
      end
      wr(IDX_XFER, XFER_CMD);
      rchk("ref_fresh", IDX_REF_STAT, ref_exp(cs[k]));
    end
  endtask

  task automatic t_readback;
    logic [7:0] ex [8] = '{8'hF1, 8'hE0, 8'hCD, 8'h2B, 8'h5C, 8'h0A, 8'hB7, 8'h03};
    @(posedge clk);
    tuning_word <= 30'h2BCD_E0F1;
    phase_lock_level <= 12'hA5C;
    freq_lock_level <= 12'h3B7;
    for (int k = 0; k < 8; k++) rchk("readback", IDX_TW0 + 12'(k), ex[k]);
  endtask

  // Ready held low for a few cycles after each answer appears
  task automatic t_stalled_bus;
    @(posedge clk);
    s_axi_araddr <= {2'b00, IDX_PH_LO, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (3) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    chk("stalled_rdata", s_axi_rdata, 32'h0000005C);
    s_axi_rready <= 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {2'b00, IDX_LOAD_COND, 2'b00};
    s_axi_wdata <= 32'h00000005;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    repeat (3) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    chk("stalled_bresp", s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
    chk("stalled_cond", nvm_load_condition, 4'h5);
  endtask

  task automatic pulse(input bit err);
    @(posedge clk);
    nvm_error <= err;
    nvm_done <= !err;
    @(posedge clk);
    nvm_error <= 1'b0;
    nvm_done <= 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(IDX_NVM_BUSY);
      n++;
    end while (rdat[BIT_BUSY] && n < 50);
    chk("busy_drop", rdat[BIT_BUSY], 1'b0);
  endtask

  task automatic t_nvm;
    wr(IDX_WPROT, 8'h01);
    chk("mapped_bresp", rsp, RESP_OKAY);
    chk("wen_pin", nvm_write_enable, 1'b1);
    wr(IDX_LOAD_COND, 8'hFA);
    chk("cond_pin", nvm_load_condition, 4'hA);
    rchk("cond", IDX_LOAD_COND, 8'h0A);
    wr(IDX_EVT_EN, 8'h03);
    wr(IDX_SAVE_TRIG, 8'h01);
    rchk("save_busy", IDX_SAVE_TRIG, 8'h01);
    chk("save_pulse", n_save, 1);
    rchk("busy", IDX_NVM_BUSY, 8'h02);
    pulse(1'b0);
    wait_idle;
    rchk("save_clear", IDX_SAVE_TRIG, 8'h00);
    rchk("evt_done", IDX_EVT_STAT, 8'h01);
    chk("irq_on", irq, 1'b1);
    wr(IDX_EVT_CLR, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_off", irq, 1'b0);
    wr(IDX_LOAD_TRIG, 8'h02);
    rchk("load_busy", IDX_LOAD_TRIG, 8'h02);
    chk("load_pulse", n_load, 1);
    pulse(1'b1);
    wait_idle;
    rchk("evt_fault", IDX_EVT_STAT, 8'h02);
    wr(IDX_EVT_EN, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq_masked", irq, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("wen_after_rst", nvm_write_enable, 1'b0);
    rchk("evt_after_rst", IDX_EVT_STAT, 8'h00);
    wr(IDX_EVT_CLR, 8'h03);
    wr(IDX_WPROT, 8'h00);
    wr(IDX_SAVE_TRIG, 8'h01);
    repeat (3) @(posedge clk);
    chk("protected_save", n_save, 1);
    rchk("evt_prot", IDX_EVT_STAT, 8'h02);
  endtask

  task automatic results;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {ref_fault, ref_timer_done, ref_fast, ref_slow, ref_missing} = '0;
    {tuning_word, phase_lock_level, freq_lock_level} = '0;
    {nvm_done, nvm_error} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_and_map;
    t_ref_status;
    t_readback;
    t_stalled_bus;
    t_nvm;
    results;
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
endmodule
